// [logic/lcu_link_cap_upper.sv]
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcu_defs.svh"
module lcu_link_cap_upper
    import lcu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_reg,
    input wire logic write_unlock,
    input wire logic port_is_downstream,
    input wire logic [7:0] port_index,
    input wire logic mode_change,
    output logic [2:0] l1_exit_latency_reg,
    output logic clock_pm_capable_reg,
    output lcu_dn_caps_type dn_caps_reg
);
    lcu_bus_req_type req;
    logic sw_mod_reg;
    logic [7:0] pidx_reg;
    logic wr_cap;
    // strap pins come from outside the clock domain; only the second stage is read
    logic strap_dn_s1_reg;
    logic strap_dn_s2_reg;
    logic [7:0] pidx_s1_reg;
    logic [7:0] pidx_s2_reg;
    logic mode_s1_reg;
    logic mode_s2_reg;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign wr_cap = req.wr && req.addr == `LCU_OFF_CAP && write_unlock;

    // default capability set for the port's current direction
    function automatic lcu_dn_caps_type dn_default(input logic dn);
        lcu_dn_caps_type c;
        c = dn ? {3{`LCU_DN_CAP_RST}} : {3{`LCU_UP_CAP_RST}};
        return c;
    endfunction : dn_default

    // the index bus may settle bit by bit; a strap is expected to hold for many cycles
    always_ff @(posedge clk_sys) begin
        strap_dn_s1_reg <= port_is_downstream;
        strap_dn_s2_reg <= strap_dn_s1_reg;
        pidx_s1_reg <= port_index;
        pidx_s2_reg <= pidx_s1_reg;
        mode_s1_reg <= mode_change;
        mode_s2_reg <= mode_s1_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            l1_exit_latency_reg <= `LCU_L1LAT_RST;
            clock_pm_capable_reg <= `LCU_CLKPM_RST;
        end else if (wr_cap) begin
            // per-function consistency is software's job, not checked here
            l1_exit_latency_reg <= req.wdata[`LCU_L1LAT_MSB:`LCU_L1LAT_LSB];
            clock_pm_capable_reg <= req.wdata[`LCU_CLKPM_BIT];
        end
    end

    // straps are followed from reset release until software writes, never under reset
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dn_caps_reg <= '0;
            sw_mod_reg <= 1'b0;
        end else if (wr_cap) begin
            dn_caps_reg <= {req.wdata[`LCU_BWN_BIT], req.wdata[`LCU_LACT_BIT], req.wdata[`LCU_SDREP_BIT]};
            sw_mod_reg <= 1'b1;
        end else if (!sw_mod_reg) begin
            // until software writes, follow the direction strap every cycle; mode_change plays no part
            dn_caps_reg <= dn_default(strap_dn_s2_reg);
        end
        // once written, a mode change leaves the value alone
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pidx_reg <= 8'h00;
        end else begin
            pidx_reg <= (pidx_s2_reg > `LCU_PIDX_MAX) ? `LCU_PIDX_MAX : pidx_s2_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req.rd && req.addr == `LCU_OFF_CAP) begin
            rdata_reg <= {pidx_reg, 2'b00, dn_caps_reg.bw_notify_cap, dn_caps_reg.link_active_report_cap,
                          dn_caps_reg.surprise_down_report_cap, clock_pm_capable_reg,
                          l1_exit_latency_reg, 15'h0000};
        end else if (req.rd && req.addr == `LCU_OFF_MODE) begin
            rdata_reg <= {30'h0000_0000, sw_mod_reg, strap_dn_s2_reg};
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    property p_l1_reset;
        @(posedge clk_sys)
        !rst_b |=> l1_exit_latency_reg == `LCU_L1LAT_RST;
    endproperty
    a_l1_reset: assert property (p_l1_reset)
        else $error("l1 latency reset wrong");

    property p_cpm_reset;
        @(posedge clk_sys)
        !rst_b |=> !clock_pm_capable_reg;
    endproperty
    a_cpm_reset: assert property (p_cpm_reset)
        else $error("clock pm reset wrong");

    property p_locked;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr && !write_unlock) |=> $stable(l1_exit_latency_reg) && $stable(clock_pm_capable_reg)
            && $stable(dn_caps_reg);
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked write took effect");

    property p_dn_def;
        @(posedge clk_sys) disable iff (!rst_b)
        (!sw_mod_reg && !wr_cap) |=> dn_caps_reg == {3{$past(strap_dn_s2_reg)}};
    endproperty
    a_dn_def: assert property (p_dn_def)
        else $error("downstream default wrong");

    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_b)
        (sw_mod_reg && !wr_cap) |=> $stable(dn_caps_reg);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky caps lost");

    property p_mode_sticky;
        @(posedge clk_sys) disable iff (!rst_b)
        (sw_mod_reg && !wr_cap && mode_s2_reg) |=> $stable(dn_caps_reg) && sw_mod_reg;
    endproperty
    a_mode_sticky: assert property (p_mode_sticky)
        else $error("mode change disturbed written caps");

    property p_rd_zero;
        @(posedge clk_sys) disable iff (!rst_b)
        (rd && addr == `LCU_OFF_CAP) |=> rdata_reg[23:22] == 2'b00 && rdata_reg[14:0] == 15'h0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("reserved bits nonzero");

    property p_pidx;
        @(posedge clk_sys) disable iff (!rst_b)
        (rd && addr == `LCU_OFF_CAP) |=> rdata_reg[31:24] <= `LCU_PIDX_MAX;
    endproperty
    a_pidx: assert property (p_pidx)
        else $error("port index out of range");

    property p_wr;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr && write_unlock && addr == `LCU_OFF_CAP) |=> l1_exit_latency_reg == $past(wdata[17:15])
            && clock_pm_capable_reg == $past(wdata[18]) && dn_caps_reg == $past(wdata[21:19]);
    endproperty
    a_wr: assert property (p_wr)
        else $error("unlocked write lost");

    property p_mode_rd;
        @(posedge clk_sys) disable iff (!rst_b)
        (rd && addr == `LCU_OFF_MODE) |=> rdata_reg[31:2] == 30'h0000_0000
            && rdata_reg[1] == $past(sw_mod_reg);
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode status word wrong");

    property p_idle_zero;
        @(posedge clk_sys) disable iff (!rst_b)
        !rd |=> rdata_reg == 32'h0000_0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data outside read cycle");
endmodule : lcu_link_cap_upper
`default_nettype wire

// [logic/lcu_defs.svh]
`ifndef LCU_DEFS_SVH
`define LCU_DEFS_SVH
`define LCU_ADDR_W 4
`define LCU_OFF_CAP 4'h0
`define LCU_OFF_MODE 4'h4
`define LCU_L1LAT_LSB 15
`define LCU_L1LAT_MSB 17
`define LCU_CLKPM_BIT 18
`define LCU_SDREP_BIT 19
`define LCU_LACT_BIT 20
`define LCU_BWN_BIT 21
`define LCU_PIDX_LSB 24
`define LCU_PIDX_MSB 31
`define LCU_L1LAT_RST 3'h2
`define LCU_CLKPM_RST 1'h0
`define LCU_DN_CAP_RST 1'h1
`define LCU_UP_CAP_RST 1'h0
`define LCU_PIDX_MAX 8'h17
`endif

// [logic/lcu_pkg.sv]
package lcu_pkg;
    typedef struct packed {
        logic bw_notify_cap;
        logic link_active_report_cap;
        logic surprise_down_report_cap;
    } lcu_dn_caps_type;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lcu_bus_req_type;
endpackage : lcu_pkg

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lcu_pkg::*;
    logic clk_sys = 0, rst_b = 0, wr = 0, rd = 0, write_unlock = 0, port_is_downstream = 1, mode_change = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata_reg, lf = 32'h21, exp_w;
    logic m_sw = 1'b0;
    logic [7:0] port_index = 8'h17;
    logic [2:0] l1_exit_latency_reg, m_l1, m_caps;
    logic clock_pm_capable_reg, m_cpm;
    lcu_dn_caps_type dn_caps_reg;
    int mismatches = 0, n_compared = 0;
    always #2 clk_sys = ~clk_sys;
    lcu_link_cap_upper i_lcu_link_cap_upper(.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_reg(rdata_reg), .write_unlock(write_unlock),
        .port_is_downstream(port_is_downstream), .port_index(port_index), .mode_change(mode_change),
        .l1_exit_latency_reg(l1_exit_latency_reg), .clock_pm_capable_reg(clock_pm_capable_reg),
        .dn_caps_reg(dn_caps_reg));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic do_reset(input logic down);
        rst_b <= 1'b0;
        port_is_downstream <= down;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        {m_caps, m_cpm, m_l1} = {down ? 3'h7 : 3'h0, 1'h0, 3'h2};
        m_sw = 1'b0;
    endtask : do_reset
    task automatic wr_t(input logic [31:0] d);
        @(posedge clk_sys);
        addr <= 4'h0;
        wdata <= d;
        wr <= 1'b1;
        if (write_unlock) begin
            {m_caps, m_cpm, m_l1} = d[21:15];
            m_sw = 1'b1;
        end
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_t
    task automatic rd_chk(input logic [3:0] a);
        logic [7:0] m_pidx;
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        // the index saturates at the last port number
        m_pidx = (port_index > 8'h17) ? 8'h17 : port_index;
        if (a == 4'h0)
            exp_w = {m_pidx, 2'h0, m_caps, m_cpm, m_l1, 15'h0};
        else if (a == 4'h4)
            exp_w = {30'h0, m_sw, port_is_downstream};
        else
            exp_w = 32'h0;
        @(negedge clk_sys);
        chk("rdata", exp_w, rdata_reg);
        chk("fields", {25'h0, m_caps, m_cpm, m_l1}, {25'h0, dn_caps_reg, clock_pm_capable_reg, l1_exit_latency_reg});
        @(posedge clk_sys);
    endtask : rd_chk
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        for (int k = 0; k < 2; k++) begin
            do_reset(k == 0);
            rd_chk(4'h0);
            rd_chk(4'h8);
            rd_chk(4'h4);
            wr_t(32'hffffffff);
            rd_chk(4'h0);
            write_unlock <= 1'b1;
            repeat (8) begin
                lf = lfsr(lf);
                wr_t(lf);
                rd_chk(4'h0);
            end
            write_unlock <= 1'b0;
            mode_change <= 1'b1;
            port_is_downstream <= k[0];
            repeat (2) @(posedge clk_sys);
            mode_change <= 1'b0;
            rd_chk(4'h0);
            rd_chk(4'h4);
            // full random byte, so the saturation above the last port is reached too
            port_index <= lf[7:0];
        end
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
